// >>> verilog/i2c_master_flag_sequencer.sv
// Interrupt-request and transfer-state flag logic of a two-wire serial port.
// Assumes SCL and SDA are open-drain pins resolved outside; strobes in swReq
// are one-cycle pulses on ref_clk from the register side.
//
// Functional notes
// - Sync format: interrupt on eighth clock rise.
// - Two-wire format: interrupt on start condition.
// - Any empty or full setting raises interrupt.
// - Start in transmit mode sets empty flag.
// - Buffer-to-shift moves set empty/full and interrupt.
// - Clear interrupt by writing 0 after reading 1.
// - Transfer-controller access clears interrupt flag.
// - Bus-busy writes leave interrupt flag alone.
// - Slave after address match: no transfer request.
// - Controller count reached: keep requests, clear buffers.
// - Receive end, buffer empty: set full, request.
// - Receive end, buffer full: keep full, no request.
// - Data read clears receive-full flag.
// - Data write clears transmit-empty flag.
// - Master two-wire: interrupt on ninth clock rise.
// - Ack check on, ack 1: flag and interrupt.
module i2c_master_flag_sequencer
   import i2c_flag_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = BUF_DEPTH
)
(
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   input  wire logic             sclIn,
   output      logic             sclOut,
   output      logic             sclOeN,
   input  wire logic             sdaIn,
   output      logic             sdaOut,
   output      logic             sdaOeN,
   input  wire logic             serialFormat,
   input  wire logic             ackCheckEnable,
   input  wire logic             addrMatchIn,
   input  wire sw_req_t          swReq,
   output      flags_t           flags,
   output      logic [WIDTH-1:0] rdData
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Wrapping pointer step, shared by both ends of the buffer
   function automatic logic [PW-1:0] ptrInc(input logic [PW-1:0] p);
      ptrInc = (p == LAST_PTR) ? '0 : p + PW'(1);
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic sclMeta_q;
   logic sclSync_q;
   logic sclPrev_q;
   logic sdaMeta_q;
   logic sdaSync_q;
   logic sdaPrev_q;

   // Two flops per pin, then a history flop for edge finding
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sclMeta_q <= 1'b1;
         sclSync_q <= 1'b1;
         sclPrev_q <= 1'b1;
         sdaMeta_q <= 1'b1;
         sdaSync_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end
      else
      begin
         sclMeta_q <= sclIn;
         sclSync_q <= sclMeta_q;
         sclPrev_q <= sclSync_q;
         sdaMeta_q <= sdaIn;
         sdaSync_q <= sdaMeta_q;
         sdaPrev_q <= sdaSync_q;
      end
   end

   logic sclRise;
   logic sclFall;
   logic startDet;
   logic stopDet;

   // Bus events; start and stop only count while SCL stays high
   always_comb
   begin
      sclRise  = sclSync_q & ~sclPrev_q;
      sclFall  = ~sclSync_q & sclPrev_q;
      startDet = serialFormat & sclSync_q & sclPrev_q & ~sdaSync_q & sdaPrev_q;
      stopDet  = serialFormat & sclSync_q & sclPrev_q & sdaSync_q & ~sdaPrev_q;
   end

   // ---------------------------------------------------------------
   // Sequencer state
   // ---------------------------------------------------------------
   phase_t           phase_q,   phase_d;
   logic [3:0]       bitCnt_q,  bitCnt_d;
   logic [WIDTH-1:0] txShift_q, txShift_d;
   logic [WIDTH-1:0] rxShift_q, rxShift_d;
   logic [WIDTH-1:0] txHold_q,  txHold_d;
   logic [WIDTH-1:0] rxHold_q,  rxHold_d;
   flags_t           flags_q,   flags_d;
   logic             irqArmed_q, irqArmed_d;
   logic             matchSeen_q, matchSeen_d;
   logic             sdaBit_q,  sdaBit_d;
   logic             sclOeN_q,  sclOeN_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [PW-1:0]    wrPtr_q,   wrPtr_d;
   logic [PW-1:0]    rdPtr_q,   rdPtr_d;
   logic [CW-1:0]    cnt_q,     cnt_d;

   logic [3:0]       lastClk;
   logic [3:0]       cntNext;
   logic             active;
   logic             slaveQuiet;
   logic             irqSet;
   logic             irqClr;
   logic             irtrSet;
   logic             pushValid;
   logic             pushReady;
   logic             popValid;
   logic             popReady;

   // Next-state logic for flags, shifting and the two-entry buffer
   always_comb
   begin
      phase_d     = phase_q;
      bitCnt_d    = bitCnt_q;
      txShift_d   = txShift_q;
      rxShift_d   = rxShift_q;
      txHold_d    = txHold_q;
      rxHold_d    = rxHold_q;
      flags_d     = flags_q;
      irqArmed_d  = irqArmed_q;
      matchSeen_d = matchSeen_q;
      sdaBit_d    = sdaBit_q;
      sclOeN_d    = 1'b1;
      mem_d       = mem_q;
      wrPtr_d     = wrPtr_q;
      rdPtr_d     = rdPtr_q;
      cnt_d       = cnt_q;
      irqSet      = 1'b0;
      irtrSet     = 1'b0;
      pushValid   = 1'b0;
      lastClk     = serialFormat ? I2C_LAST_CLK : SYNC_LAST_CLK;
      cntNext     = bitCnt_q + 4'h1;
      active      = serialFormat ? (phase_q != PH_IDLE) : 1'b1;
      slaveQuiet  = matchSeen_q & ~flags_q.masterSelect;

      // Mode selection from software
      if (swReq.modeWr)
      begin
         flags_d.masterSelect   = swReq.modeMst;
         flags_d.transmitSelect = swReq.modeTrs;
         if (swReq.modeMst)
            flags_d.arbitrationLostFlag = 1'b0;
      end
      if (swReq.dataWr)
      begin
         txHold_d                  = swReq.wrData;
         flags_d.txBufferEmptyFlag = 1'b0;
      end
      if (swReq.dataRd)
         flags_d.rxBufferFullFlag = 1'b0;
      // Programmed count reached: only buffer flags drop
      if (swReq.xferDone)
      begin
         flags_d.txBufferEmptyFlag = 1'b0;
         flags_d.rxBufferFullFlag  = 1'b0;
      end

      // Slave address match holds off transfer requests until start/stop
      if (!flags_q.masterSelect && addrMatchIn)
      begin
         matchSeen_d                 = 1'b1;
         flags_d.ownAddressMatchFlag = 1'b1;
      end

      // Drive the next data bit on the SCL fall; open drain, low only
      if (sclFall && active)
      begin
         if (flags_q.transmitSelect && bitCnt_q < ACK_SLOT_CNT)
         begin
            sdaBit_d  = txShift_q[WIDTH-1];
            txShift_d = {txShift_q[WIDTH-2:0], 1'b0};
         end
         else if (serialFormat && flags_q.masterSelect && !flags_q.transmitSelect
                  && bitCnt_q == ACK_SLOT_CNT)
            sdaBit_d = 1'b0;                 // Master receiver acknowledges
         else
            sdaBit_d = 1'b1;
      end

      if (sclRise && active)
      begin
         bitCnt_d = cntNext;
         if (bitCnt_q < ACK_SLOT_CNT)
            rxShift_d = {rxShift_q[WIDTH-2:0], sdaSync_q};
         // Released high but bus reads low: another master won
         if (serialFormat && flags_q.masterSelect && flags_q.transmitSelect
             && bitCnt_q < ACK_SLOT_CNT && sdaBit_q && !sdaSync_q)
         begin
            flags_d.masterSelect        = 1'b0;
            flags_d.transmitSelect      = 1'b0;
            flags_d.arbitrationLostFlag = 1'b1;
            sdaBit_d                    = 1'b1;
         end
         if (serialFormat && bitCnt_q == ACK_SLOT_CNT && flags_q.transmitSelect
             && ackCheckEnable && sdaSync_q)
         begin
            flags_d.receivedAckFlag = 1'b1;
            irqSet                  = 1'b1;
         end
         if (cntNext == lastClk)
         begin
            bitCnt_d = 4'h0;
            irqSet   = 1'b1;
            if (flags_q.transmitSelect && !flags_q.txBufferEmptyFlag)
            begin
               txShift_d                 = txHold_q;
               flags_d.txBufferEmptyFlag = 1'b1;
               irtrSet                   = 1'b1;
            end
            else if (!flags_q.transmitSelect)
               pushValid = 1'b1;
         end
      end

      // A received word the buffer cannot take holds SCL low until room
      if (phase_q == PH_STALL)
      begin
         pushValid = 1'b1;
         sclOeN_d  = 1'b0;
      end
      pushReady = (cnt_q != FULL_CNT);
      if (pushValid && !pushReady)
      begin
         phase_d  = PH_STALL;
         sclOeN_d = 1'b0;
      end
      else if (phase_q == PH_STALL)
         phase_d = PH_XFER;

      // Holding buffer takes a word only once software has emptied it
      popValid = (cnt_q != '0);
      popReady = ~flags_q.rxBufferFullFlag;
      if (popValid && popReady)
      begin
         rxHold_d                 = mem_q[rdPtr_q];
         rdPtr_d                  = ptrInc(rdPtr_q);
         flags_d.rxBufferFullFlag = 1'b1;
         irqSet                   = 1'b1;
         irtrSet                  = 1'b1;
      end
      if (pushValid && pushReady)
      begin
         mem_d[wrPtr_q] = rxShift_d;
         wrPtr_d        = ptrInc(wrPtr_q);
      end
      cnt_d = cnt_q + CW'(pushValid && pushReady) - CW'(popValid && popReady);

      // Start: in transmit mode the first frame moves holding data into the shifter
      if (startDet)
      begin
         flags_d.busBusyBit          = 1'b1;
         flags_d.ownAddressMatchFlag = 1'b0;
         matchSeen_d                 = 1'b0;
         phase_d                     = PH_XFER;
         bitCnt_d                    = 4'h0;
         irqSet                      = 1'b1;
         if (flags_q.transmitSelect)
         begin
            txShift_d                 = txHold_q;
            flags_d.txBufferEmptyFlag = 1'b1;
            irtrSet                   = 1'b1;
         end
      end
      if (stopDet)
      begin
         flags_d.busBusyBit        = 1'b0;
         flags_d.txBufferEmptyFlag = 1'b0;
         flags_d.ownAddressMatchFlag = 1'b0;
         matchSeen_d               = 1'b0;
         phase_d                   = PH_IDLE;
         sdaBit_d                  = 1'b1;
      end

      // Interrupt flag: set wins; bus-busy writes never reach it
      irqClr = (swReq.irqWr && !swReq.irqWrVal && irqArmed_q)
             | (swReq.xferAccess && !swReq.xferDone);
      flags_d.irqRequestFlag = (flags_q.irqRequestFlag & ~irqClr) | irqSet;
      if (irqClr)
         irqArmed_d = 1'b0;
      else if (swReq.irqRead && flags_q.irqRequestFlag)
         irqArmed_d = 1'b1;
      // Transfer request; other sources are told apart by flags
      flags_d.transferRequestFlag = (flags_q.transferRequestFlag & ~swReq.irtrClr)
                                  | (irtrSet & ~slaveQuiet);
   end

   // Register stage
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         phase_q     <= PH_IDLE;
         bitCnt_q    <= 4'h0;
         txShift_q   <= '0;
         rxShift_q   <= '0;
         txHold_q    <= '0;
         rxHold_q    <= '0;
         flags_q     <= FLAGS_RESET;
         irqArmed_q  <= 1'b0;
         matchSeen_q <= 1'b0;
         sdaBit_q    <= 1'b1;
         sclOeN_q    <= 1'b1;
         mem_q       <= '{default: '0};
         wrPtr_q     <= '0;
         rdPtr_q     <= '0;
         cnt_q       <= '0;
      end
      else
      begin
         phase_q     <= phase_d;
         bitCnt_q    <= bitCnt_d;
         txShift_q   <= txShift_d;
         rxShift_q   <= rxShift_d;
         txHold_q    <= txHold_d;
         rxHold_q    <= rxHold_d;
         flags_q     <= flags_d;
         irqArmed_q  <= irqArmed_d;
         matchSeen_q <= matchSeen_d;
         sdaBit_q    <= sdaBit_d;
         sclOeN_q    <= sclOeN_d;
         mem_q       <= mem_d;
         wrPtr_q     <= wrPtr_d;
         rdPtr_q     <= rdPtr_d;
         cnt_q       <= cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs from flops, sclOut tied low; pins only ever pull low
   // ---------------------------------------------------------------
   always_comb
   begin
      flags  = flags_q;
      rdData = rxHold_q;
      sdaOut = sdaBit_q;
      sdaOeN = sdaBit_q;
      sclOut = 1'b0;
      sclOeN = sclOeN_q;
   end

endmodule

// >>> verilog/i2c_flag_pkg.sv
// Shared types and constants for the two-wire flag sequencer.
// Assumes a single 100 MHz core clock; bus pins arrive asynchronously.
package i2c_flag_pkg;

   // ---------------------------------------------------------------
   // Sizes and counts
   // ---------------------------------------------------------------
   localparam int         DATA_W        = 8;
   localparam int         BUF_DEPTH     = 2;
   localparam logic [3:0] SYNC_LAST_CLK = 4'h8;   // Clocked synchronous byte end
   localparam logic [3:0] I2C_LAST_CLK  = 4'h9;   // Two-wire byte end, after ack
   localparam logic [3:0] ACK_SLOT_CNT  = 4'h8;   // Rises seen before the ack clock

   // ---------------------------------------------------------------
   // Link phase
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PH_IDLE  = 2'b00,
      PH_XFER  = 2'b01,
      PH_STALL = 2'b10
   } phase_t;

   // ---------------------------------------------------------------
   // Status and control flags seen by software
   // ---------------------------------------------------------------
   typedef struct packed {
      logic irqRequestFlag;
      logic txBufferEmptyFlag;
      logic rxBufferFullFlag;
      logic transferRequestFlag;
      logic busBusyBit;
      logic masterSelect;
      logic transmitSelect;
      logic arbitrationLostFlag;
      logic receivedAckFlag;
      logic ownAddressMatchFlag;
   } flags_t;

   localparam flags_t FLAGS_RESET = '0;

   // Software and transfer-controller strobes, one-cycle pulses
   typedef struct packed {
      logic              dataWr;
      logic              dataRd;
      logic              irqRead;
      logic              irqWr;
      logic              irqWrVal;
      logic              irtrClr;
      logic              xferAccess;
      logic              xferDone;
      logic              modeWr;
      logic              modeMst;
      logic              modeTrs;
      logic [DATA_W-1:0] wrData;
   } sw_req_t;

endpackage

// >>> tb/i2c_flag_sequencer_monitor.sv
// Port-level assertions for the flag sequencer.
// Assumes it is bound into the top module; everything runs on ref_clk.
module i2c_flag_sequencer_monitor
   import i2c_flag_pkg::*;
#(
   parameter int WIDTH = DATA_W
)
(
   input wire logic             ref_clk,
   input wire logic             rst_b,
   input wire logic             sclIn,
   input wire logic             sclOut,
   input wire logic             sclOeN,
   input wire logic             sdaIn,
   input wire logic             sdaOut,
   input wire logic             sdaOeN,
   input wire logic             serialFormat,
   input wire logic             ackCheckEnable,
   input wire logic             addrMatchIn,
   input wire sw_req_t          swReq,
   input wire flags_t           flags,
   input wire logic [WIDTH-1:0] rdData
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // Only these strobes may drop the interrupt flag
   logic clrCause;
   assign clrCause = (swReq.irqWr & ~swReq.irqWrVal) | swReq.xferAccess;

   // Start: SDA falls under a high SCL; the synchroniser adds delay
   sequence startSeen;
      serialFormat && sclIn && $fell(sdaIn);
   endsequence
   sequence startFlags;
      flags.busBusyBit && flags.irqRequestFlag;
   endsequence

   start_flags_a: assert property (startSeen |-> ##[2:6] startFlags)
      else $error("start did not raise busy and interrupt");
   irq_fall_a: assert property ($fell(flags.irqRequestFlag) |-> $past(clrCause))
      else $error("interrupt flag dropped without a clear");
   irq_keep_a: assert property (swReq.irqWr && swReq.irqWrVal && !swReq.xferAccess
      && flags.irqRequestFlag |=> flags.irqRequestFlag) else $error("write of one cleared irq");
   tx_set_a: assert property ($rose(flags.txBufferEmptyFlag) |-> flags.irqRequestFlag)
      else $error("empty flag rose without interrupt");
   rx_set_a: assert property ($rose(flags.rxBufferFullFlag) && flags.masterSelect
      |-> flags.irqRequestFlag && flags.transferRequestFlag) else $error("rx end flags");
   tx_clear_a: assert property (swReq.dataWr && flags.masterSelect
      && flags.transmitSelect |=> !flags.txBufferEmptyFlag) else $error("write kept empty");
   rx_clear_a: assert property (swReq.dataRd && flags.masterSelect
      && !flags.transmitSelect |=> !flags.rxBufferFullFlag) else $error("read kept full");
   done_keep_a: assert property (swReq.xferDone && flags.irqRequestFlag
      && flags.transferRequestFlag |=> flags.irqRequestFlag && flags.transferRequestFlag
      && !flags.rxBufferFullFlag && !flags.txBufferEmptyFlag) else $error("count end flags");
   stop_keep_a: assert property ($fell(flags.busBusyBit) && $past(flags.masterSelect)
      |-> flags.masterSelect && !flags.txBufferEmptyFlag) else $error("stop flags");
   arb_lost_a: assert property ($rose(flags.arbitrationLostFlag) |-> !flags.masterSelect
      && !flags.transmitSelect && flags.busBusyBit) else $error("arbitration loss flags");
endmodule

// >>> tb/i2c_bus_partner.sv
// Behavioural far-side bus device: makes SCL and drives SDA open drain.
// Assumes pull-ups on both lines; the sequencer may stretch SCL low.
module i2c_bus_partner
(
   input  wire logic sclOut,
   input  wire logic sclOeN,
   input  wire logic sdaOut,
   input  wire logic sdaOeN,
   output wire logic sclPin,
   output wire logic sdaPin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic sclDrv = 1'h1;
   logic sdaDrv = 1'h1;
   // Wired-and with pull-ups, so a released line reads high
   assign sclPin = sclDrv & (sclOeN | sclOut);
   assign sdaPin = sdaDrv & (sdaOeN | sdaOut);

   // SDA falls while SCL is high
   task automatic start;
      sclDrv = 1'h0;
      #40 sdaDrv = 1'h1;
      #40 sclDrv = 1'h1;
      #80 sdaDrv = 1'h0;
      #80;
   endtask

   // n bits MSB first, 160 ns each; a 1 in drv releases SDA
   task automatic xfer(input logic [8:0] drv, input int n, output logic [8:0] seen);
      seen = '0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sclDrv = 1'h0;
         #40 sdaDrv = drv[i];
         #40 sclDrv = 1'h1;
         while (!sclPin) #10;
         #40 seen[i] = sdaPin;
         #40;
      end
   endtask

   // SDA rises while SCL is high
   task automatic stop;
      sclDrv = 1'h0;
      #40 sdaDrv = 1'h0;
      #40 sclDrv = 1'h1;
      #80 sdaDrv = 1'h1;
      #40;
   endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the flag sequencer with a modelled bus partner.
// Assumes ref_clk at 100 MHz and SCL made by the partner at 160 ns.
module tb
   import i2c_flag_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   logic       ref_clk;
   logic       rst_b;
   logic       serialFormat;
   logic       ackCheckEnable;
   sw_req_t    swReq;
   wire        sclPin;
   wire        sdaPin;
   logic       sclOut;
   logic       sclOeN;
   logic       sdaOut;
   logic       sdaOeN;
   flags_t     flags;
   logic [7:0] rdData;
   logic [8:0] seen;
   logic       addrMatchIn;
   int         mismatches = 0;
   int         nCompared = 0;
   int         cycles = 0;

   i2c_master_flag_sequencer dut (.ref_clk(ref_clk), .rst_b(rst_b), .sclIn(sclPin),
      .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaPin), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
      .serialFormat(serialFormat), .ackCheckEnable(ackCheckEnable), .addrMatchIn(addrMatchIn),
      .swReq(swReq), .flags(flags), .rdData(rdData));
   i2c_bus_partner bus (.sclOut(sclOut), .sclOeN(sclOeN), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN), .sclPin(sclPin), .sdaPin(sdaPin));

   // Clock and hang guard; the tests need only about a thousand cycles
   initial
   begin
      ref_clk = 1'h0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 30000)
      begin
         mismatches++;
         summarize();
      end
   end

   task automatic summarize;
      if (mismatches == 0 && nCompared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [9:0] got, input logic [9:0] exp);
      nCompared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // One-cycle strobe; an idle edge first keeps drives one to a time step
   task automatic req(input sw_req_t r);
      cyc(1);
      swReq = r;
      cyc(1);
      swReq = '0;
   endtask

   function automatic sw_req_t mode(input logic m, input logic t);
      return sw_req_t'{modeWr: 1'h1, modeMst: m, modeTrs: t, default: '0};
   endfunction

   task automatic clearIrq;
      req(sw_req_t'{irqRead: 1'h1, default: '0});
      req(sw_req_t'{irqWr: 1'h1, default: '0});
   endtask

   task automatic syncEnd;
      req(mode(1'h1, 1'h0));
      bus.xfer(9'h0a5, 7, seen);
      cyc(8);
      check("irq at 7th", flags.irqRequestFlag, 1'h0);
      bus.xfer(9'h001, 1, seen);
      cyc(8);
      check("irq at 8th", flags.irqRequestFlag, 1'h1);
      clearIrq();
      req(sw_req_t'{dataRd: 1'h1, default: '0});
      serialFormat = 1'h1;
   endtask

   task automatic txFlow;
      req(mode(1'h1, 1'h1));
      req(sw_req_t'{irtrClr: 1'h1, default: '0});
      req(sw_req_t'{dataWr: 1'h1, wrData: 8'ha5, default: '0});
      bus.start();
      cyc(8);
      check("busy", flags.busBusyBit, 1'h1);
      check("irq start", flags.irqRequestFlag, 1'h1);
      check("empty start", flags.txBufferEmptyFlag, 1'h1);
      check("transfer_request_flag start", flags.transferRequestFlag, 1'h1);
      req(sw_req_t'{dataWr: 1'h1, wrData: 8'hbc, default: '0});
      check("empty wr", flags.txBufferEmptyFlag, 1'h0);
      req(sw_req_t'{irqWr: 1'h1, irqWrVal: 1'h1, default: '0});
      check("irq wr1", flags.irqRequestFlag, 1'h1);
      clearIrq();
      check("irq clr", flags.irqRequestFlag, 1'h0);
      bus.xfer(9'h1ff, 9, seen);
      cyc(8);
      check("tx bits", seen[8:1], 8'ha5);
      check("irq 9th", flags.irqRequestFlag, 1'h1);
      check("ack flag", flags.receivedAckFlag, 1'h1);
      check("empty end", flags.txBufferEmptyFlag, 1'h1);
      req(sw_req_t'{xferAccess: 1'h1, default: '0});
      check("irq access", flags.irqRequestFlag, 1'h0);
      // Receive mode first: a released bit under the partner's low SDA reads as lost
      req(mode(1'h1, 1'h0));
      bus.stop();
      cyc(8);
      check("busy stop", flags.busBusyBit, 1'h0);
      check("empty stop", flags.txBufferEmptyFlag, 1'h0);
      check("mst stop", flags.masterSelect, 1'h1);
   endtask

   task automatic rxFlow;
      req(mode(1'h1, 1'h0));
      req(sw_req_t'{irtrClr: 1'h1, default: '0});
      bus.start();
      bus.xfer({8'h5a, 1'h1}, 9, seen);
      cyc(8);
      check("full 1st", flags.rxBufferFullFlag, 1'h1);
      check("transfer_request_flag 1st", flags.transferRequestFlag, 1'h1);
      check("data 1st", rdData, 8'h5a);
      req(sw_req_t'{irtrClr: 1'h1, default: '0});
      bus.xfer({8'hc3, 1'h1}, 9, seen);
      cyc(8);
      check("full 2nd", flags.rxBufferFullFlag, 1'h1);
      check("transfer_request_flag 2nd", flags.transferRequestFlag, 1'h0);
      req(sw_req_t'{dataRd: 1'h1, default: '0});
      check("full read", flags.rxBufferFullFlag, 1'h0);
      cyc(3);
      check("data 2nd", rdData, 8'hc3);
      check("full refill", flags.rxBufferFullFlag, 1'h1);
      req(sw_req_t'{xferDone: 1'h1, default: '0});
      check("full done", flags.rxBufferFullFlag, 1'h0);
      check("irq done", flags.irqRequestFlag, 1'h1);
      check("transfer_request_flag done", flags.transferRequestFlag, 1'h1);
      bus.stop();
      cyc(8);
   endtask

   // Partner pulls SDA low while the sequencer releases its first bit
   task automatic arbLoss;
      req(mode(1'h1, 1'h1));
      req(sw_req_t'{dataWr: 1'h1, wrData: 8'h80, default: '0});
      bus.start();
      bus.xfer(9'h000, 1, seen);
      // Now a slave: an address match must hold off the request at byte end
      addrMatchIn = 1'h1;
      req(sw_req_t'{irtrClr: 1'h1, default: '0});
      addrMatchIn = 1'h0;
      bus.xfer(9'h0ff, 8, seen);
      cyc(8);
      check("match", flags.ownAddressMatchFlag, 1'h1);
      check("transfer_request_flag quiet", flags.transferRequestFlag, 1'h0);
      check("full quiet", flags.rxBufferFullFlag, 1'h1);
      check("lost", flags.arbitrationLostFlag, 1'h1);
      check("mst lost", flags.masterSelect, 1'h0);
      check("trs lost", flags.transmitSelect, 1'h0);
      check("busy lost", flags.busBusyBit, 1'h1);
      bus.stop();
      cyc(8);
   endtask

   initial
   begin
      rst_b = 1'h0;
      serialFormat = 1'h0;
      ackCheckEnable = 1'h1;
      addrMatchIn = 1'h0;
      swReq = '0;
      repeat (16) @(posedge ref_clk);
      #1 rst_b = 1'h1;
      cyc(2);
      check("flags reset", flags, FLAGS_RESET);
      check("oe reset", {sclOeN, sdaOeN}, 2'h3);
      syncEnd();
      txFlow();
      rxFlow();
      arbLoss();
      summarize();
   end
endmodule

bind i2c_master_flag_sequencer i2c_flag_sequencer_monitor #(.WIDTH(WIDTH)) mon (
   .ref_clk(ref_clk), .rst_b(rst_b), .sclIn(sclIn), .sclOut(sclOut), .sclOeN(sclOeN),
   .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .serialFormat(serialFormat),
   .ackCheckEnable(ackCheckEnable), .addrMatchIn(addrMatchIn), .swReq(swReq),
   .flags(flags), .rdData(rdData));
